// File: pnir_defs.vh
// Purpose: shared constants for the next-page, preamble and interrupt register group
// Assumes: 5-bit management register addresses, 16-bit register words
// Notes: included by every design file of the block except the input synchroniser
`ifndef PNIR_DEFS_VH
`define PNIR_DEFS_VH

// register addresses
`define PNIR_ADDR_LP_NEXT_PAGE 5'h08
`define PNIR_ADDR_PREAMBLE_CTL 5'h14
`define PNIR_ADDR_FAULT_COUNT 5'h15
`define PNIR_ADDR_INT_CTL_STAT 5'h1B
`define PNIR_ADDR_PHY_CTL2 5'h1F

// partner next-page fields
`define PNIR_NP_MORE_BIT 15
`define PNIR_NP_ACK_BIT 14
`define PNIR_NP_MSG_PAGE_BIT 13
`define PNIR_NP_ACK2_BIT 12
`define PNIR_NP_TOGGLE_BIT 11
`define PNIR_NP_RESET 16'h0000

// preamble control fields
`define PNIR_PRE100_BIT 7
`define PNIR_PRE10_BIT 6
`define PNIR_PRE_LOW_FIXED 6'h01
`define PNIR_PRE100_STRAP 3'h4
`define PNIR_PRE100_RESET 1'b0
`define PNIR_PRE10_RESET 1'b0

// symbol error frame counter
`define PNIR_COUNT_RESET 16'h0000
`define PNIR_COUNT_MAX 16'hFFFF

// interrupt control/status fields
`define PNIR_INT_EN_LSB 8
`define PNIR_INT_EN_RESET 8'h00
`define PNIR_INT_FLAG_RESET 8'h00
`define PNIR_INT_LEVEL_BIT 9
`define PNIR_INT_LEVEL_RESET 1'b0

// management frame
`define PNIR_MGMT_PRE_MIN 6'h20
`define PNIR_MGMT_OP_READ 2'h2
`define PNIR_MGMT_OP_WRITE 2'h1
`define PNIR_MGMT_HDR_LAST 4'hB
`define PNIR_MGMT_DATA_LAST 4'hF

// receive preamble, counted in nibbles
`define PNIR_NIB_PRE 4'h5
`define PNIR_DROP_100 4'h2
`define PNIR_DROP_10 4'hE

`endif

// File: pnir_sync3.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to core_clk
// Notes: output only moves once stages two and three agree
`timescale 1ns/10ps
module pnir_sync3 (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // signal
  input wire d_in,
  output reg q_out
);

reg s1_r;
reg s2_r;
reg s3_r;

always @(posedge core_clk or negedge reset_n) begin
  if (!reset_n) begin
    s1_r <= 1'b0;
    s2_r <= 1'b0;
    s3_r <= 1'b0;
    q_out <= 1'b0;
  end else begin
    s1_r <= d_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
    // s1_r feeds s2_r only, to keep metastability off the filter
    if (s2_r == s3_r) begin
      q_out <= s2_r;
    end
  end
end

endmodule // pnir_sync3

// File: pnir_preamble.v
// Purpose: receive preamble filter in front of the MII receive outputs
// Assumes: one nibble per nib_valid strobe, same clock as the register logic
// Notes: dropped nibbles show as rx_dv low; later nibbles pass unchanged
`timescale 1ns/10ps
`include "pnir_defs.vh"
module pnir_preamble (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // controls
  input wire speed_100,
  input wire restore_100,
  input wire restore_10,
  // receive nibble stream in
  input wire nib_valid,
  input wire rx_dv,
  input wire [3:0] rxd,
  // filtered stream out
  output reg out_valid,
  output reg out_dv,
  output reg [3:0] out_rxd
);

reg [3:0] nib_cnt_r;
reg in_pre_r;
wire restore = speed_100 ? restore_100 : restore_10;
wire [3:0] drop_cnt = speed_100 ? `PNIR_DROP_100 : `PNIR_DROP_10;
wire drop = rx_dv && in_pre_r && !restore && (nib_cnt_r < drop_cnt) && (rxd == `PNIR_NIB_PRE);

always @(posedge core_clk or negedge reset_n) begin
  if (!reset_n) begin
    nib_cnt_r <= 4'h0;
    in_pre_r <= 1'b1;
    out_valid <= 1'b0;
    out_dv <= 1'b0;
    out_rxd <= 4'h0;
  end else begin
    out_valid <= nib_valid;
    if (nib_valid) begin
      out_dv <= rx_dv && !drop;
      out_rxd <= drop ? 4'h0 : rxd;
      if (!rx_dv) begin
        nib_cnt_r <= 4'h0;
        in_pre_r <= 1'b1;
      end else begin
        // stop dropping at the first nibble that is not preamble
        if (rxd != `PNIR_NIB_PRE) begin
          in_pre_r <= 1'b0;
        end
        if (nib_cnt_r != 4'hF) begin
          nib_cnt_r <= nib_cnt_r + 4'h1;
        end
      end
    end
  end
end

endmodule // pnir_preamble

// File: pnir_regs.v
// Purpose: management-reachable next-page, preamble, error count and interrupt registers
// Assumes: MDC and MDIO arrive from the station manager and are oversampled by CORE_CLK
// Notes: MDC must stay well below CORE_CLK/8 so the three-stage inputs keep up
`timescale 1ns/10ps
`include "pnir_defs.vh"
module pnir_regs #(
  parameter [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET_N,
  // management pins
  input wire MDC,
  input wire MDIO_IN,
  output reg MDIO_OUT,
  output reg MDIO_OE,
  // configuration strap
  input wire [2:0] CONFIG,
  // partner next page word from auto-negotiation
  input wire [15:0] LP_NP_WORD,
  input wire LP_NP_LOAD,
  // receive datapath events
  input wire SPEED_100,
  input wire SYM_ERR_FRAME,
  // interrupt events, one-cycle pulses
  input wire JABBER_EV,
  input wire RX_ERR_EV,
  input wire PAGE_RX_EV,
  input wire PD_FAULT_EV,
  input wire LP_ACK_EV,
  input wire LINK_DOWN_EV,
  input wire REMOTE_FAULT_EV,
  input wire LINK_UP_EV,
  // interrupt pin
  output reg INTR_OUT,
  // receive nibble stream
  input wire RX_NIB_VALID,
  input wire RX_DV_IN,
  input wire [3:0] RXD_IN,
  output wire RX_NIB_VALID_OUT,
  output wire RX_DV_OUT,
  output wire [3:0] RXD_OUT
);

localparam [5:0] S_PRE = 6'b000001;
localparam [5:0] S_ST = 6'b000010;
localparam [5:0] S_HDR = 6'b000100;
localparam [5:0] S_TA = 6'b001000;
localparam [5:0] S_RD = 6'b010000;
localparam [5:0] S_WR = 6'b100000;

// synchronised pins
wire mdc_s;
wire mdio_s;
wire [2:0] cfg_s;

pnir_sync3 u_sync_mdc (
  .core_clk(CORE_CLK),
  .reset_n(RESET_N),
  .d_in(MDC),
  .q_out(mdc_s)
);

pnir_sync3 u_sync_mdio (
  .core_clk(CORE_CLK),
  .reset_n(RESET_N),
  .d_in(MDIO_IN),
  .q_out(mdio_s)
);

genvar gi;
generate
  for (gi = 0; gi < 3; gi = gi + 1) begin : g_cfg
    pnir_sync3 u_sync_cfg (
      .core_clk(CORE_CLK),
      .reset_n(RESET_N),
      .d_in(CONFIG[gi]),
      .q_out(cfg_s[gi])
    );
  end
endgenerate

// register state
reg [15:0] lp_np_r;
reg pre100_r;
reg pre10_r;
reg [15:0] fault_cnt_r;
reg [7:0] int_en_r;
reg [7:0] int_flag_r;
reg int_level_r;
reg [2:0] strap_cnt_r;
reg strap_done_r;

// management frame state
reg [5:0] state_r;
reg mdc_d_r;
reg [5:0] ones_r;
reg [3:0] bit_r;
reg [11:0] hdr_r;
reg [15:0] shift_r;
reg is_read_r;
reg wr_en_r;
reg [4:0] wr_addr_r;
reg [15:0] wr_data_r;

// the synchroniser leaves reset low while idle MDC is high: ignore that false rise
wire mdc_rise = mdc_s && !mdc_d_r && strap_done_r;
wire [11:0] hdr_full = {hdr_r[10:0], mdio_s};
wire [1:0] hdr_op = hdr_full[11:10];
wire [4:0] hdr_phy = hdr_full[9:5];
wire [4:0] hdr_reg = hdr_full[4:0];
wire hdr_done = (state_r == S_HDR) && mdc_rise && (bit_r == `PNIR_MGMT_HDR_LAST);
wire addr_hit = (hdr_phy == PHY_ADDR);
wire rd_take = hdr_done && addr_hit && (hdr_op == `PNIR_MGMT_OP_READ);
wire wr_take = hdr_done && addr_hit && (hdr_op == `PNIR_MGMT_OP_WRITE);

// self-clearing registers are captured and cleared in the same cycle
wire clr_flags = rd_take && (hdr_reg == `PNIR_ADDR_INT_CTL_STAT);
wire clr_count = rd_take && (hdr_reg == `PNIR_ADDR_FAULT_COUNT);

wire [7:0] ev_vec = {JABBER_EV, RX_ERR_EV, PAGE_RX_EV, PD_FAULT_EV,
                     LP_ACK_EV, LINK_DOWN_EV, REMOTE_FAULT_EV, LINK_UP_EV};

// read data mux
reg [15:0] rd_data;
always @* begin
  rd_data = 16'h0000;
  case (hdr_reg)
    `PNIR_ADDR_LP_NEXT_PAGE: begin
      rd_data = lp_np_r;
    end
    `PNIR_ADDR_PREAMBLE_CTL: begin
      rd_data = {8'h00, pre100_r, pre10_r, `PNIR_PRE_LOW_FIXED};
    end
    `PNIR_ADDR_FAULT_COUNT: begin
      rd_data = fault_cnt_r;
    end
    `PNIR_ADDR_INT_CTL_STAT: begin
      rd_data = {int_en_r, int_flag_r};
    end
    `PNIR_ADDR_PHY_CTL2: begin
      rd_data = 16'h0000;
      rd_data[`PNIR_INT_LEVEL_BIT] = int_level_r;
    end
    default: begin
      rd_data = 16'h0000;
    end
  endcase
end

// flags: a new event wins over the read that clears
wire [7:0] int_flag_nxt = (clr_flags ? 8'h00 : int_flag_r) | ev_vec;
wire [7:0] int_en_nxt = (wr_en_r && wr_addr_r == `PNIR_ADDR_INT_CTL_STAT) ?
                        wr_data_r[15:`PNIR_INT_EN_LSB] : int_en_r;
wire int_level_nxt = (wr_en_r && wr_addr_r == `PNIR_ADDR_PHY_CTL2) ?
                     wr_data_r[`PNIR_INT_LEVEL_BIT] : int_level_r;
wire int_any_nxt = |(int_flag_nxt & int_en_nxt);

// management frame engine
always @(posedge CORE_CLK or negedge RESET_N) begin
  if (!RESET_N) begin
    state_r <= S_PRE;
    mdc_d_r <= 1'b0;
    ones_r <= 6'h00;
    bit_r <= 4'h0;
    hdr_r <= 12'h000;
    shift_r <= 16'h0000;
    is_read_r <= 1'b0;
    wr_en_r <= 1'b0;
    wr_addr_r <= 5'h00;
    wr_data_r <= 16'h0000;
    MDIO_OUT <= 1'b0;
    MDIO_OE <= 1'b0;
  end else begin
    mdc_d_r <= mdc_s;
    wr_en_r <= 1'b0;
    if (mdc_rise) begin
      case (state_r)
        S_PRE: begin
          if (mdio_s) begin
            if (ones_r != `PNIR_MGMT_PRE_MIN) begin
              ones_r <= ones_r + 6'h01;
            end
          end else begin
            // start needs a full preamble of ones ahead of it
            if (ones_r == `PNIR_MGMT_PRE_MIN) begin
              state_r <= S_ST;
            end
            ones_r <= 6'h00;
          end
        end
        S_ST: begin
          bit_r <= 4'h0;
          state_r <= mdio_s ? S_HDR : S_PRE;
        end
        S_HDR: begin
          hdr_r <= hdr_full;
          bit_r <= bit_r + 4'h1;
          if (bit_r == `PNIR_MGMT_HDR_LAST) begin
            bit_r <= 4'h0;
            wr_addr_r <= hdr_reg;
            is_read_r <= rd_take;
            shift_r <= rd_data;
            // foreign address or opcode: go back to hunting for preamble
            state_r <= (rd_take || wr_take) ? S_TA : S_PRE;
          end
        end
        S_TA: begin
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'h0) begin
            if (is_read_r) begin
              MDIO_OE <= 1'b1;
              MDIO_OUT <= 1'b0;
            end
          end else begin
            bit_r <= 4'h0;
            if (is_read_r) begin
              MDIO_OUT <= shift_r[15];
              shift_r <= {shift_r[14:0], 1'b0};
              state_r <= S_RD;
            end else begin
              state_r <= S_WR;
            end
          end
        end
        S_RD: begin
          bit_r <= bit_r + 4'h1;
          if (bit_r == `PNIR_MGMT_DATA_LAST) begin
            MDIO_OE <= 1'b0;
            MDIO_OUT <= 1'b0;
            state_r <= S_PRE;
          end else begin
            MDIO_OUT <= shift_r[15];
            shift_r <= {shift_r[14:0], 1'b0};
          end
        end
        S_WR: begin
          bit_r <= bit_r + 4'h1;
          shift_r <= {shift_r[14:0], mdio_s};
          if (bit_r == `PNIR_MGMT_DATA_LAST) begin
            wr_en_r <= 1'b1;
            wr_data_r <= {shift_r[14:0], mdio_s};
            state_r <= S_PRE;
          end
        end
        default: begin
          state_r <= S_PRE;
          MDIO_OE <= 1'b0;
        end
      endcase
    end
  end
end

// register file
always @(posedge CORE_CLK or negedge RESET_N) begin
  if (!RESET_N) begin
    lp_np_r <= `PNIR_NP_RESET;
    pre100_r <= `PNIR_PRE100_RESET;
    pre10_r <= `PNIR_PRE10_RESET;
    fault_cnt_r <= `PNIR_COUNT_RESET;
    int_en_r <= `PNIR_INT_EN_RESET;
    int_flag_r <= `PNIR_INT_FLAG_RESET;
    int_level_r <= `PNIR_INT_LEVEL_RESET;
    strap_cnt_r <= 3'h0;
    strap_done_r <= 1'b0;
    INTR_OUT <= 1'b1;
  end else begin
    if (LP_NP_LOAD) begin
      lp_np_r <= LP_NP_WORD;
    end
    // strap is read once the synchroniser has settled after release
    if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
      if (strap_cnt_r == 3'h5) begin
        strap_done_r <= 1'b1;
        pre100_r <= (cfg_s == `PNIR_PRE100_STRAP);
      end
    end
    if (wr_en_r && wr_addr_r == `PNIR_ADDR_PREAMBLE_CTL) begin
      pre100_r <= wr_data_r[`PNIR_PRE100_BIT];
      pre10_r <= wr_data_r[`PNIR_PRE10_BIT];
    end
    // count saturates rather than wrapping back to a small number
    if (clr_count) begin
      fault_cnt_r <= SYM_ERR_FRAME ? 16'h0001 : 16'h0000;
    end else if (SYM_ERR_FRAME && fault_cnt_r != `PNIR_COUNT_MAX) begin
      fault_cnt_r <= fault_cnt_r + 16'h0001;
    end
    int_flag_r <= int_flag_nxt;
    int_en_r <= int_en_nxt;
    int_level_r <= int_level_nxt;
    INTR_OUT <= int_level_nxt ? int_any_nxt : !int_any_nxt;
  end
end

// receive preamble handling
pnir_preamble u_preamble (
  .core_clk(CORE_CLK),
  .reset_n(RESET_N),
  .speed_100(SPEED_100),
  .restore_100(pre100_r),
  .restore_10(pre10_r),
  .nib_valid(RX_NIB_VALID),
  .rx_dv(RX_DV_IN),
  .rxd(RXD_IN),
  .out_valid(RX_NIB_VALID_OUT),
  .out_dv(RX_DV_OUT),
  .out_rxd(RXD_OUT)
);

endmodule // pnir_regs

// File: pnir_chk.sv
// Purpose: port-level checks for pnir_regs
// Assumes: MDC stands still between management frames
// Notes: register contents are checked by the bench, not here
`timescale 1ns/10ps
module pnir_chk (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET_N,
  // management and interrupt pins
  input wire MDC,
  input wire MDIO_OUT,
  input wire MDIO_OE,
  input wire INTR_OUT,
  // events
  input wire JABBER_EV,
  input wire RX_ERR_EV,
  input wire PAGE_RX_EV,
  input wire PD_FAULT_EV,
  input wire LP_ACK_EV,
  input wire LINK_DOWN_EV,
  input wire REMOTE_FAULT_EV,
  input wire LINK_UP_EV,
  // nibble stream
  input wire RX_NIB_VALID,
  input wire RX_DV_IN,
  input wire [3:0] RXD_IN,
  input wire RX_NIB_VALID_OUT,
  input wire RX_DV_OUT,
  input wire [3:0] RXD_OUT
);
  reg [4:0] quiet_r;
  reg mdc_d_r;
  wire ev_any = JABBER_EV | RX_ERR_EV | PAGE_RX_EV | PD_FAULT_EV | LP_ACK_EV | LINK_DOWN_EV | REMOTE_FAULT_EV | LINK_UP_EV;
  // cycles since MDC last moved; writes and read-clears only happen near MDC edges
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      quiet_r <= 5'h00;
      mdc_d_r <= 1'b0;
    end else begin
      mdc_d_r <= MDC;
      if (MDC != mdc_d_r)
        quiet_r <= 5'h00;
      else if (quiet_r != 5'h1F)
        quiet_r <= quiet_r + 5'h01;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  chk_valid_delay: assert property (RX_NIB_VALID |=> RX_NIB_VALID_OUT)
    else $error("nibble valid not delayed by one");
  chk_sfd_passes: assert property (RX_NIB_VALID && RX_DV_IN && RXD_IN != 4'h5 |=> RX_DV_OUT)
    else $error("non-preamble nibble dropped");
  chk_dv_cause: assert property (RX_DV_OUT |-> $past(RX_DV_IN) && $past(RX_NIB_VALID))
    else $error("dv out without dv in");
  chk_pass_data: assert property (RX_DV_OUT |-> RXD_OUT == $past(RXD_IN))
    else $error("passed nibble altered");
  chk_drop_zero: assert property (RX_NIB_VALID_OUT && $past(RX_DV_IN) && !RX_DV_OUT |-> RXD_OUT == 4'h0 && $past(RXD_IN) == 4'h5)
    else $error("bad dropped nibble");
  // an MDC phase lasts five cycles at most, so eight quiet cycles means no frame is running
  chk_irq_cause: assert property (quiet_r > 5'h07 && $changed(INTR_OUT) |-> $past(ev_any))
    else $error("interrupt moved without cause");
  chk_reset_idle: assert property ($rose(RESET_N) |-> !MDIO_OE && INTR_OUT)
    else $error("pins not idle after reset");
  chk_ta_hold: assert property ($rose(MDIO_OE) |-> (MDIO_OE && !MDIO_OUT) [*8])
    else $error("turnaround zero not held");
endmodule // pnir_chk
bind pnir_regs pnir_chk chk (.*);

// File: pnir_mgmt_model.sv
// Purpose: station manager model sending management frames
// Assumes: the bench resolves the wire with a pull-up
// Notes: MDC stands still high between frames
`timescale 1ns/10ps
module pnir_mgmt_model #(
  parameter [4:0] PHY = 5'h01
) (
  // clock
  input wire clk,
  // management wire
  input wire mdio,
  output reg mdc,
  output reg m_oe,
  output reg m_bit
);
  initial begin
    mdc = 1'b1;
    m_oe = 1'b0;
    m_bit = 1'b0;
  end
  // one frame, four to five clocks per MDC phase
  task frame(input [1:0] op, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    reg [63:0] f;
    reg [15:0] acc;
    integer i;
    begin
      f = {32'hFFFFFFFF, 2'b01, op, PHY, ra, 2'b10, wd};
      acc = 16'h0000;
      for (i = 63; i >= 0; i = i - 1) begin
        @(posedge clk);
        #1;
        mdc = 1'b0;
        m_oe = op == 2'b01 || i > 17;
        m_bit = f[i];
        repeat (4) @(posedge clk);
        #1;
        if (i < 16)
          acc = {acc[14:0], mdio};
        mdc = 1'b1;
        repeat (4) @(posedge clk);
      end
      @(posedge clk);
      #1;
      m_oe = 1'b0;
      rd = acc;
    end
  endtask
endmodule // pnir_mgmt_model

// File: pnir_regs_test.sv
// Purpose: self-checking bench for pnir_regs
// Assumes: 50 MHz core clock, MDC at a ninth of it
// Notes: random words come from a fixed-seed xorshift
`timescale 1ns/10ps
module pnir_regs_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] cfg = 3'h4;
  reg [15:0] np_word = 16'h0000;
  reg np_load = 1'b0;
  reg speed = 1'b0;
  reg sym_err = 1'b0;
  reg [7:0] ev = 8'h00;
  reg nib_v = 1'b0;
  reg dv_in = 1'b0;
  reg [3:0] rxd = 4'h0;
  reg [31:0] seed = 32'h397F7608;
  reg [4:0] n5;
  wire mdc, m_oe, m_bit, d_out, d_oe, intr, v_out, dv_out;
  wire [3:0] rxd_out;
  // pull-up when nobody drives
  wire mdio = d_oe ? d_out : (m_oe ? m_bit : 1'b1);
  integer failures = 0;
  integer total_checks = 0;
  integer i, j, n;
  pnir_regs #(.PHY_ADDR(5'h01)) uut (.CORE_CLK(clk), .RESET_N(rst_n), .MDC(mdc), .MDIO_IN(mdio),
    .MDIO_OUT(d_out), .MDIO_OE(d_oe), .CONFIG(cfg), .LP_NP_WORD(np_word), .LP_NP_LOAD(np_load),
    .SPEED_100(speed), .SYM_ERR_FRAME(sym_err), .JABBER_EV(ev[7]), .RX_ERR_EV(ev[6]), .PAGE_RX_EV(ev[5]),
    .PD_FAULT_EV(ev[4]), .LP_ACK_EV(ev[3]), .LINK_DOWN_EV(ev[2]), .REMOTE_FAULT_EV(ev[1]),
    .LINK_UP_EV(ev[0]), .INTR_OUT(intr), .RX_NIB_VALID(nib_v), .RX_DV_IN(dv_in), .RXD_IN(rxd),
    .RX_NIB_VALID_OUT(v_out), .RX_DV_OUT(dv_out), .RXD_OUT(rxd_out));
  pnir_mgmt_model #(.PHY(5'h01)) mgr (.clk(clk), .mdio(mdio), .mdc(mdc), .m_oe(m_oe), .m_bit(m_bit));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [4:0] kept(input s, input r);
    kept = r ? 5'h14 : (s ? 5'h12 : 5'h06);
  endfunction
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task cmp(input [8*10-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task chk_rd(input [8*10-1:0] nm, input [4:0] a, input [15:0] e);
    reg [15:0] d;
    begin
      mgr.frame(2'b10, a, 16'h0000, d);
      cmp(nm, e, d);
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    reg [15:0] x;
    begin
      mgr.frame(2'b01, a, d, x);
      repeat (4) tick;
    end
  endtask
  task do_reset(input [2:0] c);
    begin
      rst_n = 1'b0;
      cfg = c;
      repeat (12) tick;
      rst_n = 1'b1;
      repeat (12) tick;
    end
  endtask
  // 15 nibbles of 5, SFD nibble D, four random nibbles
  // then one strobed nibble with dv low: the filter only rearms on a strobed idle nibble
  task send_frame(output [4:0] cnt);
    integer k;
    begin
      cnt = 5'h00;
      for (k = 0; k < 22; k = k + 1) begin
        nib_v = k < 21;
        dv_in = k < 20;
        rxd = k < 15 ? 4'h5 : (k == 15 ? 4'hD : seed[3:0]);
        seed = xs(seed);
        tick;
        if (v_out && dv_out)
          cnt = cnt + 5'h01;
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures = failures + 1;
    close_out;
  end
  initial begin
    do_reset(3'h4);
    chk_rd("pre_strap", 5'h14, 16'h0081);
    chk_rd("np_reset", 5'h08, 16'h0000);
    chk_rd("cnt_reset", 5'h15, 16'h0000);
    chk_rd("int_reset", 5'h1B, 16'h0000);
    chk_rd("unmapped", 5'h03, 16'h0000);
    cmp("intr_idle", 16'h0001, {15'h0000, intr});
    do_reset(3'h0);
    chk_rd("pre_reset", 5'h14, 16'h0001);
    wr(5'h14, 16'hFFFF);
    chk_rd("pre_rw", 5'h14, 16'h00C1);
    // unknown opcode must leave the register alone
    mgr.frame(2'b11, 5'h14, 16'h0000, np_word);
    chk_rd("bad_op", 5'h14, 16'h00C1);
    $display("end reset and access");
    for (j = 0; j < 2; j = j + 1) begin
      np_word = j ? ~seed[15:0] : seed[15:0];
      np_load = 1'b1;
      tick;
      np_load = 1'b0;
      chk_rd("np_word", 5'h08, np_word);
    end
    seed = xs(seed);
    for (j = 0; j < 4; j = j + 1) begin
      speed = j[0];
      wr(5'h14, {8'h00, j[1], j[1], 6'h00});
      send_frame(n5);
      cmp("kept", {11'h000, kept(j[0], j[1])}, {11'h000, n5});
    end
    $display("end next page and preamble");
    n = {28'h0000000, seed[3:0]} + 1;
    for (i = 0; i < n; i = i + 1) begin
      sym_err = 1'b1;
      tick;
      sym_err = 1'b0;
      tick;
    end
    chk_rd("cnt", 5'h15, n[15:0]);
    chk_rd("cnt_clr", 5'h15, 16'h0000);
    $display("end counter");
    wr(5'h1F, 16'h0200);
    for (i = 0; i < 8; i = i + 1) begin
      wr(5'h1B, 16'h0100 << i);
      ev = 8'h01 << i;
      tick;
      ev = 8'h00;
      tick;
      cmp("intr_on", 16'h0001, {15'h0000, intr});
      chk_rd("int_stat", 5'h1B, 16'h0101 << i);
      cmp("intr_off", 16'h0000, {15'h0000, intr});
      chk_rd("int_clr", 5'h1B, 16'h0100 << i);
    end
    wr(5'h1B, 16'h0000);
    ev = 8'h01;
    tick;
    ev = 8'h00;
    tick;
    cmp("masked", 16'h0000, {15'h0000, intr});
    wr(5'h1F, 16'h0000);
    wr(5'h1B, 16'h0100);
    cmp("act_low", 16'h0000, {15'h0000, intr});
    // jabber lands after the capture point of the read
    fork
      chk_rd("rd_race", 5'h1B, 16'h0101);
      begin
        repeat (500) tick;
        ev = 8'h80;
        tick;
        ev = 8'h00;
      end
    join
    chk_rd("kept_ev", 5'h1B, 16'h0180);
    cmp("low_idle", 16'h0001, {15'h0000, intr});
    $display("end interrupts");
    close_out;
  end
endmodule // pnir_regs_test
